/* edc_dev_cap.sv */
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module edc_dev_cap
  import edc_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [edc_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [edc_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                     wr_i,
  input  wire logic                     rd_i,
  input  wire logic                     hotplug_en_i,
  input  wire logic                     reverse_i,
  input  wire edc_pkg::edc_spl_msg_type spl_msg_i,
  output var  logic [edc_pkg::DATA_W-1:0] rd_data_o,
  output var  logic [3:0]               port_type_o,
  output var  edc_pkg::edc_spl_type     spl_o
);

  edc_spl_type           spl_w;
  logic                  seen_w;
  edc_devcap_type        devcap_w;
  logic [DATA_W-1:0]     status_w;

  logic [DATA_W-1:0]     rd_data_r;
  logic [DATA_W-1:0]     rd_data_nxt;
  logic [3:0]            port_type_r;
  logic [3:0]            port_type_nxt;
  logic                  hp_present_r;
  logic                  hp_present_nxt;
  logic [7:0]            msg_count_r;
  logic [7:0]            msg_count_nxt;

  edc_spl_capture u_spl_capture
  (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .msg_i     (spl_msg_i),
    .spl_o     (spl_w),
    .seen_o    (seen_w)
  );

  // Port type and hot-plug presence are registered so the read path sees stable levels; the status reverse and hot-plug bits are not.
  always_comb
  begin
    port_type_nxt  = reverse_i ? PORT_TYPE_REVERSE : PORT_TYPE_FORWARD;
    hp_present_nxt = hotplug_en_i & ~reverse_i;
  end

  // A message arriving in the same cycle as a clear still counts.
  always_comb
  begin
    msg_count_nxt = msg_count_r;
    if (wr_i && (addr_i == CTRL_OFFSET) && wr_data_i[CTRL_CLR_BIT])
    begin
      msg_count_nxt = 8'h00;
    end
    if (spl_msg_i.valid)
    begin
      msg_count_nxt = msg_count_nxt + 8'h01;
    end
  end

  always_comb
  begin
    devcap_w             = '0;
    devcap_w.max_payload = MAX_PAYLOAD_RESET;
    devcap_w.phantom     = PHANTOM_RESET;
    devcap_w.ext_tag     = EXT_TAG_RESET;
    devcap_w.l0s_lat     = L0S_LAT_RESET;
    devcap_w.l1_lat      = L1_LAT_RESET;
    devcap_w.attn_btn    = hp_present_r;
    devcap_w.attn_ind    = hp_present_r;
    devcap_w.pwr_ind     = hp_present_r;
    devcap_w.spl_value   = spl_w.value;
    devcap_w.spl_scale   = spl_w.scale;
  end

  always_comb
  begin
    status_w                                  = '0;
    status_w[STAT_COUNT_LSB +: 8]             = msg_count_r;
    status_w[STAT_PTYPE_LSB +: 4]             = port_type_r;
    status_w[STAT_REVERSE_BIT]                = reverse_i;
    status_w[STAT_HOTPLUG_BIT]                = hotplug_en_i;
    status_w[STAT_SEEN_BIT]                   = seen_w;
  end

  // Read data stand for one cycle only; unmapped reads return zero.
  // Writes to the capability word fall through and change nothing.
  always_comb
  begin
    rd_data_nxt = '0;
    if (rd_i)
    begin
      case (addr_i)
        DEVCAP_OFFSET: rd_data_nxt = devcap_w;
        STATUS_OFFSET: rd_data_nxt = status_w;
        default:       rd_data_nxt = '0;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      rd_data_r    <= '0;
      port_type_r  <= PORT_TYPE_FORWARD;
      hp_present_r <= 1'b0;
      msg_count_r  <= 8'h00;
    end
    else
    begin
      rd_data_r    <= rd_data_nxt;
      port_type_r  <= port_type_nxt;
      hp_present_r <= hp_present_nxt;
      msg_count_r  <= msg_count_nxt;
    end
  end

  assign rd_data_o   = rd_data_r;
  assign port_type_o = port_type_r;
  assign spl_o       = spl_w;

endmodule
`default_nettype wire

/* edc_pkg.sv */
package edc_pkg;

  localparam int unsigned ADDR_W = 12;
  localparam int unsigned DATA_W = 32;

  localparam logic [ADDR_W-1:0] DEVCAP_OFFSET = 12'h0B4;
  localparam logic [ADDR_W-1:0] CTRL_OFFSET   = 12'h100;
  localparam logic [ADDR_W-1:0] STATUS_OFFSET = 12'h104;

  localparam logic [2:0] MAX_PAYLOAD_RESET = 3'h2;
  localparam logic [1:0] PHANTOM_RESET     = 2'h0;
  localparam logic       EXT_TAG_RESET     = 1'b1;
  localparam logic [2:0] L0S_LAT_RESET     = 3'h0;
  localparam logic [2:0] L1_LAT_RESET      = 3'h0;
  localparam logic [7:0] SPL_VALUE_RESET   = 8'h00;
  localparam logic [1:0] SPL_SCALE_RESET   = 2'h0;

  localparam logic [3:0] PORT_TYPE_FORWARD = 4'h7;
  localparam logic [3:0] PORT_TYPE_REVERSE = 4'h8;

  localparam int unsigned CTRL_CLR_BIT     = 0;
  localparam int unsigned STAT_COUNT_LSB   = 0;
  localparam int unsigned STAT_PTYPE_LSB   = 8;
  localparam int unsigned STAT_REVERSE_BIT = 12;
  localparam int unsigned STAT_HOTPLUG_BIT = 13;
  localparam int unsigned STAT_SEEN_BIT    = 14;

  typedef struct packed {
    logic [3:0] rsvd_hi;
    logic [1:0] spl_scale;
    logic [7:0] spl_value;
    logic [2:0] rsvd_mid;
    logic       pwr_ind;
    logic       attn_ind;
    logic       attn_btn;
    logic [2:0] l1_lat;
    logic [2:0] l0s_lat;
    logic       ext_tag;
    logic [1:0] phantom;
    logic [2:0] max_payload;
  } edc_devcap_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] value;
    logic [1:0] scale;
  } edc_spl_msg_type;

  typedef struct packed {
    logic [7:0] value;
    logic [1:0] scale;
  } edc_spl_type;

endpackage

/* edc_spl_capture.sv */
`timescale 1ns/1ps
`default_nettype none
module edc_spl_capture
  import edc_pkg::*;
(
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire edc_pkg::edc_spl_msg_type msg_i,
  output var  edc_pkg::edc_spl_type     spl_o,
  output var  logic                     seen_o
);

  edc_spl_type spl_r;
  edc_spl_type spl_nxt;
  logic        seen_r;
  logic        seen_nxt;

  // Each message overwrites both fields; there is no accumulation.
  always_comb
  begin
    spl_nxt  = spl_r;
    seen_nxt = seen_r;
    if (msg_i.valid)
    begin
      spl_nxt.value = msg_i.value;
      spl_nxt.scale = msg_i.scale;
      seen_nxt      = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge reset_n_i)
  begin
    if (!reset_n_i)
    begin
      spl_r.value <= SPL_VALUE_RESET;
      spl_r.scale <= SPL_SCALE_RESET;
      seen_r      <= 1'b0;
    end
    else
    begin
      spl_r  <= spl_nxt;
      seen_r <= seen_nxt;
    end
  end

  assign spl_o  = spl_r;
  assign seen_o = seen_r;

endmodule
`default_nettype wire

/* edc_dev_cap_sva.sv */
`timescale 1ns/1ps
`default_nettype none
module edc_dev_cap_sva
  import edc_pkg::*;
(
  input wire logic                     clk_i,
  input wire logic                     reset_n_i,
  input wire logic [ADDR_W-1:0]        addr_i,
  input wire logic                     rd_i,
  input wire logic                     hotplug_en_i,
  input wire logic                     reverse_i,
  input wire edc_pkg::edc_spl_msg_type spl_msg_i,
  input wire logic [DATA_W-1:0]        rd_data_o,
  input wire logic [3:0]               port_type_o,
  input wire edc_pkg::edc_spl_type     spl_o
);
  import edc_pkg::*;
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  logic rc;
  assign rc = rd_i && addr_i == DEVCAP_OFFSET;
  AST_PAYLOAD: assert property (rc |=> rd_data_o[2:0] == 3'h2)
    else $error("payload field wrong");
  AST_TAG: assert property (rc |=> rd_data_o[5:3] == 3'h4)
    else $error("phantom or tag field wrong");
  AST_LATENCY: assert property (rc |=> rd_data_o[11:6] == 6'h00)
    else $error("latency fields wrong");
  AST_HOTPLUG: assert property (rc && $past(reset_n_i) && $stable(hotplug_en_i)
    && $stable(reverse_i) |=> rd_data_o[14:12] == {3{$past(hotplug_en_i) & ~$past(reverse_i)}})
    else $error("hot-plug bits wrong");
  AST_SPL: assert property (spl_msg_i.valid |=>
    spl_o == {$past(spl_msg_i.value), $past(spl_msg_i.scale)}) else $error("capture wrong");
  AST_SPL_WORD: assert property (rc |=>
    rd_data_o[27:18] == {$past(spl_o.scale), $past(spl_o.value)})
    else $error("power limit bits wrong");
  AST_PORT_TYPE: assert property ($past(reset_n_i) |-> port_type_o ==
    ($past(reverse_i) ? PORT_TYPE_REVERSE : PORT_TYPE_FORWARD)) else $error("port type wrong");
  AST_RSVD: assert property (rc |=> rd_data_o[31:28] == 4'h0 && rd_data_o[17:15] == 3'h0)
    else $error("reserved bits set");
endmodule
`default_nettype wire

/* edc_spl_partner.sv */
`timescale 1ns/1ps
`default_nettype none
module edc_spl_partner
  import edc_pkg::*;
(
  input  wire logic                     clk_i,
  output var  edc_pkg::edc_spl_msg_type msg_o
);
  initial msg_o = '0;
  task automatic send(input logic [7:0] v, input logic [1:0] s);
    @(posedge clk_i);
    msg_o <= {1'b1, v, s};
  endtask
  // Released payload lines show the inverse so stale values never pass.
  task automatic idle();
    @(posedge clk_i);
    msg_o <= {1'b0, ~msg_o[9:0]};
  endtask
endmodule
`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import edc_pkg::*;
  logic clk_i = 1'b0, reset_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic hotplug_en_i = 1'b1, reverse_i = 1'b0;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wr_data_i = '0, rd_data_o, d;
  logic [3:0] port_type_o;
  edc_spl_msg_type spl_msg_i;
  edc_spl_type spl_o;
  int failures = 0, n_tests = 0, cyc = 0;
  always #12.5 clk_i = ~clk_i;
  edc_dev_cap uut (.clk_i, .reset_n_i, .addr_i, .wr_data_i, .wr_i, .rd_i, .hotplug_en_i,
    .reverse_i, .spl_msg_i, .rd_data_o, .port_type_o, .spl_o);
  edc_spl_partner p (.clk_i, .msg_o(spl_msg_i));
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      failures++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic acc(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] v);
    @(posedge clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= w;
    rd_i <= !w;
    @(posedge clk_i);
    wr_i <= 1'b0;
    rd_i <= 1'b0;
    #1 d = rd_data_o;
  endtask
  function automatic logic [31:0] cap(input logic h, input logic [9:0] s);
    return {4'h0, s[1:0], s[9:2], 3'h0, {3{h}}, 6'h00, 6'h22};
  endfunction
  task automatic t_modes();
    for (int i = 0; i < 4; i++)
    begin
      @(posedge clk_i);
      hotplug_en_i <= i[0];
      reverse_i <= i[1];
      repeat (2) @(posedge clk_i);
      acc(1'b0, DEVCAP_OFFSET, '0);
      chk("cap", d, cap(i == 1, 10'h000));
      chk("ptype", {28'h0, port_type_o}, i[1] ? 32'h8 : 32'h7);
    end
    @(posedge clk_i);
    hotplug_en_i <= 1'b1;
    reverse_i <= 1'b0;
  endtask
  task automatic t_msg();
    p.send(8'hA5, 2'h3);
    p.send(8'h3C, 2'h1);
    p.idle();
    repeat (2) @(posedge clk_i);
    chk("spl", {22'h0, spl_o}, 32'h0F1);
    acc(1'b0, DEVCAP_OFFSET, '0);
    chk("cap_spl", d, cap(1'b1, 10'h0F1));
  endtask
  task automatic t_write();
    acc(1'b1, DEVCAP_OFFSET, 32'hFFFFFFFF);
    acc(1'b0, DEVCAP_OFFSET, '0);
    chk("cap_wr", d, cap(1'b1, 10'h0F1));
    acc(1'b0, 12'h0FC, '0);
    chk("unmapped", d, 32'h0);
  endtask
  // A clear and a message taken at the same edge leave a count of one.
  task automatic t_status();
    acc(1'b0, STATUS_OFFSET, '0);
    chk("status", d, 32'h00006702);
    acc(1'b1, CTRL_OFFSET, 32'h00000001);
    acc(1'b0, STATUS_OFFSET, '0);
    chk("status_clr", d, 32'h00006700);
    fork
      acc(1'b1, CTRL_OFFSET, 32'h00000001);
      begin
        p.send(8'h3C, 2'h1);
        p.idle();
      end
    join
    acc(1'b0, STATUS_OFFSET, '0);
    chk("status_both", d, 32'h00006701);
    chk("spl_both", {22'h0, spl_o}, 32'h0F1);
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 400)
    begin
      failures++;
      stop_test();
    end
  end
  initial
  begin
    repeat (5) @(posedge clk_i);
    reset_n_i <= 1'b1;
    t_modes();
    t_msg();
    t_write();
    t_status();
    stop_test();
  end
endmodule
bind edc_dev_cap edc_dev_cap_sva sva (.clk_i, .reset_n_i, .addr_i, .rd_i, .hotplug_en_i,
  .reverse_i, .spl_msg_i, .rd_data_o, .port_type_o, .spl_o);
`default_nettype wire
